/* pkg/aoc_pkg.sv */
// aoc_pkg: register map, field layout and timing for the offset compensation block
// assumes: AXI4-Lite slave with 32-bit data, 10 MHz clock
package aoc_pkg;
  // ----------------------------------------------------------------
  // register indices (printed offsets are not all multiples of four)
  // ----------------------------------------------------------------
  localparam logic [7:0] AOC_IDX_CTRL   = 8'h36;  // offset_comp_control
  localparam logic [7:0] AOC_IDX_SET    = 8'h37;  // offset_comp_settings
  localparam logic [7:0] AOC_IDX_OFS_X  = 8'h38;  // x_axis_correction
  localparam logic [7:0] AOC_IDX_OFS_Y  = 8'h39;  // y_axis_correction
  localparam logic [7:0] AOC_IDX_OFS_Z  = 8'h3a;  // z_axis_correction
  localparam logic [7:0] AOC_IDX_IRQ_ST = 8'h40;  // sticky event status, read only
  localparam logic [7:0] AOC_IDX_IRQ_EN = 8'h41;  // event enable
  localparam logic [7:0] AOC_IDX_IRQ_CL = 8'h42;  // write one to clear status
  localparam logic [7:0] AOC_IDX_NVM    = 8'h43;  // nvm store / reload command
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int AOC_CTRL_CLEAR = 7;   // clear-all command, write only
  localparam int AOC_CTRL_TRIGH = 6;   // axis trigger high bit
  localparam int AOC_CTRL_TRIGL = 5;   // axis trigger low bit
  localparam int AOC_CTRL_RDY   = 4;   // completion flag, read only
  localparam int AOC_SET_CUTOFF = 0;   // high-pass corner select
  localparam int AOC_NVM_STORE  = 0;   // store corrections
  localparam int AOC_NVM_LOAD   = 1;   // reload corrections
  // ----------------------------------------------------------------
  // codes and constants
  // ----------------------------------------------------------------
  localparam logic [1:0] AOC_AX_NONE = 2'h0;
  localparam logic [1:0] AOC_TGT_POS = 2'h1;   // +1 g
  localparam logic [1:0] AOC_TGT_NEG = 2'h2;   // -1 g
  localparam int         AOC_ACC_W   = 12;     // acceleration sample width
  localparam int         AOC_G_SHIFT = 3;      // log2 of 12-bit lsb per correction lsb (8 lsb; 1 g = 1024)
  localparam logic signed [11:0] AOC_ONE_G = 12'sh400;
  localparam logic [7:0] AOC_RST_VAL = 8'h00;
  // slow loop step rates
  localparam int AOC_CLK_HZ    = 10_000_000;
  localparam int AOC_LO_HZ     = 1;
  localparam int AOC_HI_HZ     = 10;
  localparam int AOC_STEP_LO   = AOC_CLK_HZ / (AOC_LO_HZ * 256);
  localparam int AOC_STEP_HI   = AOC_CLK_HZ / (AOC_HI_HZ * 256);
  localparam int AOC_FAST_AVG  = 16;   // samples averaged by fast compensation
  // events
  localparam int AOC_EV_DONE = 0;
  localparam int AOC_EV_NVM  = 1;
  localparam int AOC_EV_W    = 2;
  typedef enum logic [2:0] {
    AOC_IDLE = 3'h1,
    AOC_ACC  = 3'h2,
    AOC_DONE = 3'h4
  } aoc_fast_e;
endpackage

/* pkg/aoc_nvm_if.sv */
// aoc_nvm_if: link between the control logic and the correction store
// assumes: both ends on the same clock
`timescale 1ns/10ps
interface aoc_nvm_if;
  logic       store;     // pulse: copy corrections to store
  logic       load;      // pulse: read back all three
  logic [23:0] wdata;    // {z,y,x}
  logic [23:0] rdata;    // registered read data
  logic       rvalid;    // pulse: rdata holds stored words
  modport ctl (output store, load, wdata, input rdata, rvalid);
  modport mem (input store, load, wdata, output rdata, rvalid);
endinterface

/* src/aoc_nvm.sv */
// aoc_nvm: non-volatile image of the three corrections
// assumes: contents survive the block reset (no reset on the array)
`timescale 1ns/10ps
module aoc_nvm
  import aoc_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // link to controller
  aoc_nvm_if.mem    nvm
);
  // ----------------------------------------------------------------
  // storage array, no reset so it outlives soft reset
  // ----------------------------------------------------------------
  logic [23:0] image_q;  // stored {z,y,x}
  always_ff @(posedge clk_i) begin
    if (nvm.store) begin
      image_q <= nvm.wdata;
    end
  end
  // registered read port
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nvm.rdata  <= 24'h00_0000;
      nvm.rvalid <= 1'b0;
    end else begin
      nvm.rvalid <= nvm.load;
      if (nvm.load) begin
        nvm.rdata <= image_q;
      end
    end
  end
endmodule

/* src/aoc_top.sv */
// aoc_top: offset compensation for a three-axis accelerometer
// assumes: AXI4-Lite master, samples arrive as valid pulses on clk_i
// What this block does
// - writing clear bit zeroes all corrections
// - axis code 01/10/11 starts x/y/z compensation
// - ready reads zero while compensation runs
// - three bits enable slow compensation per axis
// - target 00/11 zero, 01 plus, 10 minus
// - corner bit picks 1 Hz or 10 Hz
// - correction added to filtered and raw data
// - correction is signed, fixed g scaling
// - corrections stored, reloaded after every reset
// - corrections writable and loaded by compensation
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
module aoc_top
  import aoc_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  // axi4-lite write
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // sensor samples {z,y,x}, same clock
  input  wire logic [35:0]         raw_i,
  input  wire logic [35:0]         filt_i,
  input  wire logic                sample_valid_i,
  // compensated samples
  output logic [35:0]              raw_o,
  output logic [35:0]              filt_o,
  output logic                     sample_valid_o,
  // interrupt
  output logic                     irq_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]        ofs_q [3];        // corrections x,y,z
  logic [2:0]        slow_en_q;        // slow_comp_{z,y,x}_enable
  logic [6:0]        set_q;            // settings register
  logic [AOC_EV_W-1:0] ev_st_q;        // sticky status
  logic [AOC_EV_W-1:0] ev_en_q;        // enables
  aoc_fast_e         fst_q;            // fast compensation state
  logic [1:0]        fax_q;            // axis under compensation
  logic [4:0]        fcnt_q;           // samples collected
  logic signed [15:0] fsum_q;          // accumulated raw reading
  logic              boot_q;           // reload pending after reset
  logic              nvm_store_q;
  logic              nvm_load_q;
  aoc_nvm_if         nvm_bus ();
  aoc_nvm u_nvm (.clk_i(clk_i), .reset_n_i(reset_n_i), .nvm(nvm_bus));
  assign nvm_bus.store = nvm_store_q;
  assign nvm_bus.load  = nvm_load_q;
  assign nvm_bus.wdata = {ofs_q[2], ofs_q[1], ofs_q[0]};
  // ----------------------------------------------------------------
  // axi write: take address and data in any order, answer once both
  // ----------------------------------------------------------------
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_idx_q;
  logic [31:0] w_data_q;
  logic        w_strb0_q;
  logic        wr_go;
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_idx_q      <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb0_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      // ready one cycle, only while slot is empty
      s_axi_awready <= !aw_hold_q && s_axi_awvalid && !s_axi_awready;
      s_axi_wready  <= !w_hold_q && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q  <= 1'b1;
        w_data_q  <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;   // unmapped writes are ignored, okay
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  logic wr_en;     // a register write lands this cycle
  logic busy;      // fast compensation running
  logic [1:0] trig;
  assign wr_en = wr_go && w_strb0_q;
  assign busy  = (fst_q != AOC_IDLE);
  assign trig  = w_data_q[AOC_CTRL_TRIGH:AOC_CTRL_TRIGL];
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slow_en_q <= 3'h0;
      set_q     <= 7'h00;
      ev_en_q   <= '0;
    end else if (wr_en) begin
      case (aw_idx_q)
        AOC_IDX_CTRL:   slow_en_q <= w_data_q[2:0];
        AOC_IDX_SET:    set_q     <= w_data_q[6:0];
        AOC_IDX_IRQ_EN: ev_en_q   <= w_data_q[AOC_EV_W-1:0];
        default:        ;
      endcase
    end
  end
  // nvm commands and boot reload
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boot_q      <= 1'b1;
      nvm_store_q <= 1'b0;
      nvm_load_q  <= 1'b0;
    end else begin
      boot_q      <= 1'b0;
      nvm_load_q  <= boot_q || (wr_en && aw_idx_q == AOC_IDX_NVM
                                && w_data_q[AOC_NVM_LOAD]);
      nvm_store_q <= wr_en && aw_idx_q == AOC_IDX_NVM && w_data_q[AOC_NVM_STORE];
    end
  end
  // ----------------------------------------------------------------
  // fast compensation: average raw reading, correction = target - mean
  // ----------------------------------------------------------------
  logic [11:0] ax_raw;
  logic signed [11:0] tgt_g;
  logic [1:0]  tgt_code;
  logic signed [15:0] res_full;
  logic [7:0]  res_sat;
  always_comb begin
    case (fax_q)
      2'h1:    begin ax_raw = raw_i[11:0];  tgt_code = set_q[2:1]; end
      2'h2:    begin ax_raw = raw_i[23:12]; tgt_code = set_q[4:3]; end
      default: begin ax_raw = raw_i[35:24]; tgt_code = set_q[6:5]; end
    endcase
    // 00 and 11 both mean 0 g
    case (tgt_code)
      AOC_TGT_POS: tgt_g = AOC_ONE_G;
      AOC_TGT_NEG: tgt_g = -AOC_ONE_G;
      default:     tgt_g = 12'sh000;
    endcase
    // mean over 16 samples, scaled to correction lsb
    res_full = 16'(tgt_g >>> AOC_G_SHIFT) - (fsum_q >>> (4 + AOC_G_SHIFT));
    if (res_full > 16'sd127) res_sat = 8'h7f;
    else if (res_full < -16'sd128) res_sat = 8'h80;
    else res_sat = res_full[7:0];
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fst_q  <= AOC_IDLE;
      fax_q  <= AOC_AX_NONE;
      fcnt_q <= 5'h00;
      fsum_q <= 16'sh0000;
    end else begin
      case (fst_q)
        AOC_IDLE: begin
          // nonzero code starts, ignored while busy
          if (wr_en && aw_idx_q == AOC_IDX_CTRL && trig != AOC_AX_NONE) begin
            fst_q  <= AOC_ACC;
            fax_q  <= trig;
            fcnt_q <= 5'h00;
            fsum_q <= 16'sh0000;
          end
        end
        AOC_ACC: begin
          if (sample_valid_i) begin
            fsum_q <= fsum_q + 16'(signed'(ax_raw));
            fcnt_q <= fcnt_q + 5'h01;
            if (fcnt_q == 5'(AOC_FAST_AVG - 1)) fst_q <= AOC_DONE;
          end
        end
        AOC_DONE: fst_q <= AOC_IDLE;
        default:  fst_q <= AOC_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // slow compensation: nudge correction against the filtered sample at 256 times the corner rate
  // ----------------------------------------------------------------
  logic [17:0] div_q;
  logic        step;
  logic [17:0] div_end;
  assign div_end = set_q[AOC_SET_CUTOFF] ? 18'(AOC_STEP_HI - 1) : 18'(AOC_STEP_LO - 1);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_q <= 18'h0_0000;
      step  <= 1'b0;
    end else begin
      step  <= (div_q >= div_end);
      div_q <= (div_q >= div_end) ? 18'h0_0000 : div_q + 18'h0_0001;
    end
  end
  // ----------------------------------------------------------------
  // corrections: clear > reload > fast result > host write > slow step
  // ----------------------------------------------------------------
  logic slow_ok;
  assign slow_ok = step && sample_valid_i && !busy;
  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_ax
      logic signed [11:0] s;
      assign s = filt_i[a*12 +: 12];
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          ofs_q[a] <= AOC_RST_VAL;
        end else if (wr_en && aw_idx_q == AOC_IDX_CTRL && w_data_q[AOC_CTRL_CLEAR]) begin
          ofs_q[a] <= AOC_RST_VAL;
        end else if (nvm_bus.rvalid) begin
          ofs_q[a] <= nvm_bus.rdata[a*8 +: 8];
        end else if (fst_q == AOC_DONE && fax_q == 2'(a + 1)) begin
          ofs_q[a] <= res_sat;
        end else if (wr_en && aw_idx_q == 8'(AOC_IDX_OFS_X + a)) begin
          ofs_q[a] <= w_data_q[7:0];
        end else if (slow_ok && slow_en_q[a]) begin
          // step toward zero output, hold at the range ends
          if (s > 12'sh000 && ofs_q[a] != 8'h80) ofs_q[a] <= ofs_q[a] - 8'h01;
          else if (s < 12'sh000 && ofs_q[a] != 8'h7f) ofs_q[a] <= ofs_q[a] + 8'h01;
        end
      end
      // add signed correction at fixed g scaling
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          raw_o[a*12 +: 12]  <= 12'h000;
          filt_o[a*12 +: 12] <= 12'h000;
        end else if (sample_valid_i) begin
          raw_o[a*12 +: 12]  <= raw_i[a*12 +: 12]
                                + 12'({{4{ofs_q[a][7]}}, ofs_q[a]} << AOC_G_SHIFT);
          filt_o[a*12 +: 12] <= filt_i[a*12 +: 12]
                                + 12'({{4{ofs_q[a][7]}}, ofs_q[a]} << AOC_G_SHIFT);
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) sample_valid_o <= 1'b0;
    else sample_valid_o <= sample_valid_i;
  end
  // ----------------------------------------------------------------
  // events: set wins over clear
  // ----------------------------------------------------------------
  logic [AOC_EV_W-1:0] ev_set, ev_clr;
  assign ev_set = {nvm_bus.rvalid, fst_q == AOC_DONE};
  assign ev_clr = (wr_en && aw_idx_q == AOC_IDX_IRQ_CL) ? w_data_q[AOC_EV_W-1:0] : '0;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev_st_q <= '0;
      irq_o   <= 1'b0;
    end else begin
      ev_st_q <= (ev_st_q & ~ev_clr) | ev_set;
      irq_o   <= |(((ev_st_q & ~ev_clr) | ev_set) & ev_en_q);
    end
  end
  // ----------------------------------------------------------------
  // axi read
  // ----------------------------------------------------------------
  logic [7:0] rd_val;
  logic [7:0] ar_idx;
  assign ar_idx = s_axi_araddr[9:2];
  always_comb begin
    case (ar_idx)
      // ready bit is inverse of busy
      AOC_IDX_CTRL:   rd_val = {3'h0, !busy, 1'b0, slow_en_q};
      AOC_IDX_SET:    rd_val = {1'b0, set_q};
      AOC_IDX_OFS_X:  rd_val = ofs_q[0];
      AOC_IDX_OFS_Y:  rd_val = ofs_q[1];
      AOC_IDX_OFS_Z:  rd_val = ofs_q[2];
      AOC_IDX_IRQ_ST: rd_val = 8'(ev_st_q);
      AOC_IDX_IRQ_EN: rd_val = 8'(ev_en_q);
      default:        rd_val = 8'h00;
    endcase
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_val};
        s_axi_rresp  <= 2'h0;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  clear_zeroes_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && aw_idx_q == AOC_IDX_CTRL && w_data_q[AOC_CTRL_CLEAR])
    |=> (ofs_q[0] == 8'h00 && ofs_q[1] == 8'h00 && ofs_q[2] == 8'h00))
    else $error("clear did not zero corrections");
  trigger_starts_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (fst_q == AOC_IDLE && wr_en && aw_idx_q == AOC_IDX_CTRL && trig != AOC_AX_NONE)
    |=> (fst_q == AOC_ACC && fax_q == $past(trig)))
    else $error("trigger did not start compensation");
  ready_busy_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (fst_q == AOC_ACC) |-> !rd_val[AOC_CTRL_RDY] || ar_idx != AOC_IDX_CTRL)
    else $error("ready read one while busy");
  cutoff_div_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $stable(set_q) |-> div_q <= div_end)
    else $error("wrong corner divider");
  add_raw_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sample_valid_i && ofs_q[0] == 8'h00 |=> raw_o[11:0] == $past(raw_i[11:0]))
    else $error("zero correction changed raw data");
  nvm_boot_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(nvm_load_q) |=> nvm_bus.rvalid)
    else $error("reload did not answer");
  done_ready_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (fst_q == AOC_DONE) |=> (fst_q == AOC_IDLE && ev_st_q[AOC_EV_DONE]))
    else $error("completion did not return to ready");
  host_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && aw_idx_q == AOC_IDX_OFS_Y && !nvm_bus.rvalid && fst_q != AOC_DONE
     && !(aw_idx_q == AOC_IDX_CTRL)) |=> ofs_q[1] == $past(w_data_q[7:0]))
    else $error("host write to y correction lost");
endmodule

/* test/tb.sv */
// tb: self-checking bench for the accelerometer offset compensation block
// assumes: aoc_top as axi4-lite slave, 10 MHz clock, async low reset
`timescale 1ns/10ps
module tb
  import aoc_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_i;           // 100 ns clock
  logic        reset_n_i;       // async reset, active low
  logic [31:0] s_axi_awaddr;    // write address
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;     // write data, byte in bits 7:0
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [31:0] s_axi_araddr;    // read address
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [35:0] raw_i;           // samples {z,y,x}
  logic [35:0] filt_i;
  logic        sample_valid_i;
  logic [35:0] raw_o;           // compensated samples
  logic [35:0] filt_o;
  logic        sample_valid_o;
  logic        irq_o;           // level interrupt
  int          bad_count;       // mismatches seen
  int          checked;         // comparisons made
  // ----------------------------------------------------------------
  // device under test
  // ----------------------------------------------------------------
  aoc_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .raw_i(raw_i), .filt_i(filt_i),
    .sample_valid_i(sample_valid_i), .raw_o(raw_o), .filt_o(filt_o),
    .sample_valid_o(sample_valid_o), .irq_o(irq_o));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // a wait that ran out of cycles
  task automatic fail_to();
    bad_count++;
    $display("MISMATCH %0t wait timed out", $time);
    summarize();
  endtask
  // compare and report
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // axi write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    s_axi_awaddr  <= {22'h0, idx, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (n > 50) fail_to();
    end while (s_axi_bvalid !== 1'b1);
    chk({34'h0, s_axi_bresp}, 36'h0, "bresp");
    s_axi_bready <= 1'b0;
  endtask
  // axi read: data taken at the rvalid edge
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] e, input string m);
    int n;
    @(posedge clk_i);
    s_axi_araddr  <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (n > 50) fail_to();
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    if (m != "") chk({2'h0, s_axi_rresp, s_axi_rdata}, {28'h0, e}, m);
    else chk({4'h0, s_axi_rdata & ~(32'h1 << AOC_CTRL_RDY)}, {28'h0, e}, "poll");
  endtask
  // one sample pulse, returns at the falling edge after outputs update
  task automatic samp(input logic [35:0] r, input logic [35:0] f);
    @(posedge clk_i);
    raw_i          <= r;
    filt_i         <= f;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    @(negedge clk_i);
  endtask
  // axis value plus correction at 8 output lsb per correction lsb
  function automatic logic [11:0] cmp(input logic [11:0] v, input logic [7:0] c);
    return v + {c[7], c, 3'b000};
  endfunction
  // irq level after two edges
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({35'h0, irq_o}, {35'h0, e}, "irq level");
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // control fields, corner select, unmapped place
  task automatic t_regs();
    rdchk(AOC_IDX_CTRL, 8'h10, "ctrl after reset");
    rdchk(AOC_IDX_SET, 8'h00, "settings after reset");
    axw(AOC_IDX_SET, 8'h01);
    rdchk(AOC_IDX_SET, 8'h01, "corner select");
    axw(AOC_IDX_CTRL, 8'h05);
    rdchk(AOC_IDX_CTRL, 8'h15, "slow enables x z");
    axw(AOC_IDX_CTRL, 8'h02);
    rdchk(AOC_IDX_CTRL, 8'h12, "slow enable y");
    axw(AOC_IDX_CTRL, 8'h00);
    rdchk(8'h50, 8'h00, "unmapped read");
    $display("test regs done");
  endtask
  // corrections added to raw and filtered data, extremes of the range
  task automatic t_corr();
    axw(AOC_IDX_OFS_X, 8'h7f);
    axw(AOC_IDX_OFS_Y, 8'h80);
    axw(AOC_IDX_OFS_Z, 8'h05);
    rdchk(AOC_IDX_OFS_Y, 8'h80, "host write y");
    samp({12'h010, 12'h123, 12'h100}, {12'hff0, 12'h000, 12'h001});
    chk(raw_o, {cmp(12'h010, 8'h05), cmp(12'h123, 8'h80), cmp(12'h100, 8'h7f)}, "raw");
    chk(filt_o, {cmp(12'hff0, 8'h05), 12'hc00, cmp(12'h001, 8'h7f)}, "filt");
    chk({35'h0, sample_valid_o}, 36'h1, "sample valid out");
    $display("test corr done");
  endtask
  // clear command, zero keeps, trigger code zero starts nothing
  task automatic t_clear();
    axw(AOC_IDX_CTRL, 8'h00);
    rdchk(AOC_IDX_OFS_X, 8'h7f, "clear zero keeps");
    rdchk(AOC_IDX_CTRL, 8'h10, "code zero idle");
    axw(AOC_IDX_CTRL, 8'h80);
    for (int i = 0; i < 3; i++) begin
      rdchk(AOC_IDX_OFS_X + i[7:0], 8'h00, "clear all");
    end
    $display("test clear done");
  endtask
  // store, reload by command and after a reset
  task automatic t_nvm();
    axw(AOC_IDX_OFS_X, 8'h12);
    axw(AOC_IDX_OFS_Y, 8'h34);
    axw(AOC_IDX_OFS_Z, 8'h56);
    axw(AOC_IDX_NVM, 8'h01);
    repeat (4) @(posedge clk_i);
    axw(AOC_IDX_CTRL, 8'h80);
    axw(AOC_IDX_NVM, 8'h02);
    repeat (6) @(posedge clk_i);
    rdchk(AOC_IDX_OFS_X, 8'h12, "reload command");
    axw(AOC_IDX_CTRL, 8'h80);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdchk(AOC_IDX_OFS_X, 8'h12, "reset reload x");
    rdchk(AOC_IDX_OFS_Y, 8'h34, "reset reload y");
    rdchk(AOC_IDX_OFS_Z, 8'h56, "reset reload z");
    rdchk(AOC_IDX_IRQ_ST, 8'h02, "reload event");
    $display("test nvm done");
  endtask
  // fast compensation on each axis with targets 0 g, -1 g, 0 g (code 11)
  task automatic t_fast();
    int n;
    axw(AOC_IDX_IRQ_CL, 8'h03);
    axw(AOC_IDX_IRQ_EN, 8'h01);
    axw(AOC_IDX_SET, 8'h70);
    for (int a = 1; a < 4; a++) begin
      axw(AOC_IDX_CTRL, {1'b0, a[1:0], 5'h00});
      rdchk(AOC_IDX_CTRL, 8'h00, "busy while running");
      n = 0;
      do begin
        samp({12'h028, 12'hc18, 12'h050}, {12'h028, 12'hc18, 12'h050});
        rdchk(AOC_IDX_CTRL, 8'h00, "");
        n++;
        if (n > 40) fail_to();
      end while (s_axi_rdata[AOC_CTRL_RDY] !== 1'b1);
    end
    rdchk(AOC_IDX_OFS_X, 8'hf6, "fast x to 0 g");
    rdchk(AOC_IDX_OFS_Y, 8'hfd, "fast y to -1 g");
    rdchk(AOC_IDX_OFS_Z, 8'hfb, "fast z code 11");
    rdchk(AOC_IDX_IRQ_ST, 8'h01, "done event");
    irqchk(1'b1);
    axw(AOC_IDX_IRQ_EN, 8'h00);
    irqchk(1'b0);
    axw(AOC_IDX_IRQ_EN, 8'h01);
    irqchk(1'b1);
    axw(AOC_IDX_IRQ_CL, 8'h01);
    irqchk(1'b0);
    $display("test fast done");
  endtask
  // slow step on x only, 10 Hz corner
  task automatic t_slow();
    axw(AOC_IDX_SET, 8'h01);
    axw(AOC_IDX_CTRL, 8'h81);
    @(posedge clk_i);
    filt_i <= 36'h0_0100_1001;
    sample_valid_i <= 1'b1;
    repeat (AOC_STEP_HI) @(posedge clk_i);
    sample_valid_i <= 1'b0;
    rdchk(AOC_IDX_OFS_X, 8'hff, "slow x");
    rdchk(AOC_IDX_OFS_Y, 8'h00, "slow y off");
    $display("test slow done");
  endtask
  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    bad_count      = 0;
    checked        = 0;
    reset_n_i      = 1'b0;
    s_axi_awaddr   = 32'h0;
    s_axi_awvalid  = 1'b0;
    s_axi_wdata    = 32'h0;
    s_axi_wstrb    = 4'hf;
    s_axi_wvalid   = 1'b0;
    s_axi_bready   = 1'b0;
    s_axi_araddr   = 32'h0;
    s_axi_arvalid  = 1'b0;
    s_axi_rready   = 1'b0;
    raw_i          = 36'h0;
    filt_i         = 36'h0;
    sample_valid_i = 1'b0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_corr();
    t_clear();
    t_nvm();
    t_fast();
    t_slow();
    summarize();
  end
endmodule
